// ==== rtl/ccr_defs.vh ====
`ifndef CCR_DEFS_VH
`define CCR_DEFS_VH
// Register byte offsets
`define CCR_OFS_CTRL      12'h404
`define CCR_OFS_MODE      12'h408
`define CCR_OFS_IRQ_STAT  12'h4a0
`define CCR_OFS_IRQ_CLR   12'h4a4
`define CCR_OFS_IRQ_EN    12'h4a8
`define CCR_OFS_MEM_START 12'h4ac
`define CCR_OFS_FRAME     12'h4b0
// capture_control fields
`define CCR_CTRL_ENABLE   0
`define CCR_CTRL_BUSY     1
// sync_and_mode_setting fields
`define CCR_MODE_RSZ_FEED 19
`define CCR_MODE_VP2MEM   18
`define CCR_MODE_WEN      17
`define CCR_MODE_SYNC_EN  16
`define CCR_MODE_FIELD    15
`define CCR_MODE_LPF      14
`define CCR_MODE_FMT_HI   13
`define CCR_MODE_FMT_LO   12
// Input format codes
`define CCR_FMT_RAW       2'h0
`define CCR_FMT_YC16      2'h1
`define CCR_FMT_YC8       2'h2
`define CCR_FMT_RSVD      2'h3
// Interrupt event bits
`define CCR_IRQ_VSYNC     0
`define CCR_IRQ_WINDOW    1
`define CCR_IRQ_BITS      2
// frame_setup fields and reset values
`define CCR_FRAME_OUT     31
`define CCR_RST_LINE_LAST 12'h2cf
`define CCR_RST_FRAME_LAST 12'h20c
`define CCR_RST_MEM_START 12'h000
// Pin synchroniser depth
`define CCR_SYNC_STAGES   3
`endif

// ==== rtl/ccr_pin_sync.v ====
`timescale 1ns/1ps
`default_nettype none
// Three-stage synchroniser; output moves only when stages two and three agree
module ccr_pin_sync #(
  parameter W = 1
) (
  input  wire         pclk,    // System clock
  input  wire         presetn, // Async reset, active low
  input  wire [W-1:0] pin,     // Asynchronous pin levels
  output reg  [W-1:0] level    // Filtered synchronous level
);
  reg [W-1:0] s1;
  reg [W-1:0] s2;
  reg [W-1:0] s3;
  integer i;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1    <= {W{1'b0}};
      s2    <= {W{1'b0}};
      s3    <= {W{1'b0}};
      level <= {W{1'b0}};
    end else begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
      for (i = 0; i < W; i = i + 1) begin
        if (s2[i] == s3[i]) begin
          level[i] <= s3[i];
        end
      end
    end
  end
endmodule // ccr_pin_sync
`default_nettype wire

// ==== rtl/ccr_capture_ctrl.v ====
// How it works
// - Busy flag read-only; enable bit switches controller
// - Bit 19 forwards memory readback to resizer
// - Bit 18 routes video port to memory
// - Start line/pixel measured on video port stream when bit 18 routes it, else on sensor pins
// - Raw writes only while bit 17 latched
// - Bit 16 runs timing generator, drive or lock
// - Bit 15 shows field, 0 odd 1 even
// - Bit 14 enables 3-tap low-pass, latched
// - Interrupt events raised even when disabled
//
// Our own choices: the address map and the APB slave port.
`include "ccr_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module ccr_capture_ctrl (
  input  wire        pclk,         // System clock, 40 MHz
  input  wire        presetn,      // Async reset, active low
  input  wire        psel,         // APB select
  input  wire        penable,      // APB access phase
  input  wire        pwrite,       // APB write
  input  wire [11:0] paddr,        // APB byte address
  input  wire [31:0] pwdata,       // APB write data
  output reg  [31:0] prdata,       // APB read data
  output reg         pready,       // APB ready
  output reg         pslverr,      // APB error on unmapped address
  input  wire        pix_clk,      // Sensor pixel clock pin
  input  wire        vsync_in,     // Vertical sync pin level
  input  wire        hsync_in,     // Horizontal sync pin level
  input  wire        field_in,     // Field id pin level
  input  wire [15:0] pix_data,     // Sensor pixel data pins
  output reg         vsync_out,    // Vertical sync drive value
  output reg         vsync_oe_n,   // Vertical sync enable, low drives
  output reg         hsync_out,    // Horizontal sync drive value
  output reg         hsync_oe_n,   // Horizontal sync enable, low drives
  input  wire        vp_valid,     // Video port pixel valid
  input  wire        vp_sol,       // Video port start of line
  input  wire        vp_sof,       // Video port start of frame
  input  wire [15:0] vp_data,      // Video port pixel
  output reg         mem_wr_valid, // Formatter write strobe
  output reg  [15:0] mem_wr_data,  // Formatter write data
  input  wire        mem_rd_valid, // Memory readback valid
  input  wire [15:0] mem_rd_data,  // Memory readback data
  output reg         rsz_valid,    // Resizer input valid
  output reg  [15:0] rsz_data,     // Resizer input data
  output reg         irq           // Level interrupt
);
  ////////////////////////////////////////////////////////////////////////
  reg        enable;
  reg        busy;
  reg        rsz_feed;
  reg        vp2mem;
  reg        wen;
  reg        sync_en;
  reg        field_status;
  reg        antialias_filter_on;
  reg  [1:0] fmt;
  reg        vp2mem_l;
  reg        wen_l;
  reg        lpf_l;
  reg  [1:0] irq_stat;
  reg  [1:0] irq_en;
  reg [11:0] start_line;
  reg [11:0] start_pixel;
  reg [11:0] line_last;
  reg [11:0] frame_last;
  reg        sync_out;
  wire [3:0] pin_lvl;
  reg  [3:0] pin_prev;
  reg [15:0] data_s1;
  reg [15:0] data_s2;
  reg [15:0] d0;
  reg [15:0] d1;
  reg [15:0] d2;
  reg [11:0] h_cnt;
  reg [11:0] v_cnt;
  reg [11:0] vp_h;
  reg [11:0] vp_v;
  reg        half;
  reg  [7:0] low_byte;
  reg        win_d;
  reg        next_irq;

  ccr_pin_sync #(
    .W (4)
  ) u_pin_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .pin     ({field_in, hsync_in, vsync_in, pix_clk}),
    .level   (pin_lvl)
  );

  ////////////////////////////////////////////////////////////////////////
  // Pin edges and sync pulses
  wire tick    = pin_lvl[0] & ~pin_prev[0];
  wire vs_edge = pin_lvl[1] & ~pin_prev[1];
  wire hs_edge = pin_lvl[2] & ~pin_prev[2];
  wire gen_out = sync_en & sync_out;
  wire at_eol  = (h_cnt == line_last);
  wire at_eof  = (v_cnt == frame_last);
  wire hs_pulse = gen_out ? (tick & at_eol) : hs_edge;
  wire vs_pulse = gen_out ? (tick & at_eol & at_eof) : vs_edge;

  // Start line/pixel follow the video port stream when routed
  wire raw_win = (v_cnt >= start_line) && (h_cnt >= start_pixel);
  wire vp_win  = (vp_v >= start_line) && (vp_h >= start_pixel);
  wire win     = vp2mem_l ? vp_win : raw_win;

  // 3-tap [1 2 1]/4 low-pass; bypass keeps the same latency
  wire [17:0] lp_sum = {2'b00, d0} + {1'b0, d1, 1'b0} + {2'b00, d2};
  wire [15:0] filt   = lpf_l ? lp_sum[17:2] : d1;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_prev <= 4'h0;
      data_s1  <= 16'h0000;
      data_s2  <= 16'h0000;
    end else begin
      pin_prev <= pin_lvl;
      // Data is stable well around the pixel edge at a 200 ns period,
      // so two stages keep it aligned with the filtered clock edge.
      data_s1  <= pix_data;
      data_s2  <= data_s1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Timing generator: free-runs when driving, relocks on pin edges
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      h_cnt <= 12'h000;
      v_cnt <= 12'h000;
    end else if (sync_en) begin
      if (vs_pulse) begin
        h_cnt <= 12'h000;
        v_cnt <= 12'h000;
      end else if (hs_pulse) begin
        h_cnt <= 12'h000;
        v_cnt <= v_cnt + 12'h001;
      end else if (tick) begin
        h_cnt <= h_cnt + 12'h001;
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vsync_out  <= 1'b0;
      hsync_out  <= 1'b0;
      vsync_oe_n <= 1'b1;
      hsync_oe_n <= 1'b1;
    end else begin
      vsync_oe_n <= ~gen_out;
      hsync_oe_n <= ~gen_out;
      vsync_out  <= gen_out & (v_cnt == 12'h000);
      hsync_out  <= gen_out & (h_cnt == 12'h000);
    end
  end

  // Video port position counters
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vp_h <= 12'h000;
      vp_v <= 12'h000;
    end else if (vp_sof) begin
      vp_h <= 12'h000;
      vp_v <= 12'h000;
    end else if (vp_sol) begin
      vp_h <= 12'h000;
      vp_v <= vp_v + 12'h001;
    end else if (vp_valid) begin
      vp_h <= vp_h + 12'h001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Frame-latched settings, busy and field
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vp2mem_l     <= 1'b0;
      wen_l        <= 1'b0;
      lpf_l        <= 1'b0;
      busy         <= 1'b0;
      field_status <= 1'b0;
    end else if (vs_pulse) begin
      vp2mem_l <= vp2mem;
      wen_l    <= wen;
      lpf_l    <= antialias_filter_on;
      busy     <= enable;
      // Driving: fields alternate; locked: field pin sampled at sync
      field_status <= gen_out ? ~field_status : pin_lvl[3];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pixel pipeline and formatter write path
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      d0           <= 16'h0000;
      d1           <= 16'h0000;
      d2           <= 16'h0000;
      half         <= 1'b0;
      low_byte     <= 8'h00;
      mem_wr_valid <= 1'b0;
      mem_wr_data  <= 16'h0000;
      win_d        <= 1'b0;
    end else begin
      mem_wr_valid <= 1'b0;
      win_d        <= win;
      if (tick) begin
        d0 <= data_s2;
        d1 <= d0;
        d2 <= d1;
      end
      if (hs_pulse) begin
        half <= 1'b0;
      end
      if (enable && vp2mem_l) begin
        if (vp_valid && vp_win) begin
          mem_wr_valid <= 1'b1;
          mem_wr_data  <= vp_data;
        end
      end else if (enable && wen_l && tick && raw_win) begin
        case (fmt)
          `CCR_FMT_RAW, `CCR_FMT_YC16: begin
            mem_wr_valid <= 1'b1;
            mem_wr_data  <= filt;
          end
          `CCR_FMT_YC8: begin
            // Two 8-bit samples pack into one word, first in the low byte
            if (half) begin
              mem_wr_valid <= 1'b1;
              mem_wr_data  <= {filt[7:0], low_byte};
            end else begin
              low_byte <= filt[7:0];
            end
            half <= ~half;
          end
          default: begin
            // Reserved format captures nothing
            half <= 1'b0;
          end
        endcase
      end
    end
  end

  // Memory readback forwarding to the resizer
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rsz_valid <= 1'b0;
      rsz_data  <= 16'h0000;
    end else begin
      rsz_valid <= rsz_feed & mem_rd_valid;
      if (rsz_feed && mem_rd_valid) begin
        rsz_data <= mem_rd_data;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // APB slave: zero wait states, read data prepared in the setup cycle
  wire setup   = psel & ~penable;
  wire wr_acc  = psel & penable & pwrite;
  wire map_hit = (paddr == `CCR_OFS_CTRL) || (paddr == `CCR_OFS_MODE) ||
                 (paddr == `CCR_OFS_IRQ_STAT) || (paddr == `CCR_OFS_IRQ_CLR) ||
                 (paddr == `CCR_OFS_IRQ_EN) || (paddr == `CCR_OFS_MEM_START) ||
                 (paddr == `CCR_OFS_FRAME);
  wire [1:0] irq_evt = {win & ~win_d, vs_pulse};
  wire [1:0] irq_clr = (wr_acc && paddr == `CCR_OFS_IRQ_CLR) ? pwdata[1:0] : 2'b00;
  wire [1:0] next_stat = (irq_stat & ~irq_clr) | irq_evt;

  reg [31:0] rd_mux;
  always @* begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      `CCR_OFS_CTRL: begin
        rd_mux[`CCR_CTRL_ENABLE] = enable;
        rd_mux[`CCR_CTRL_BUSY]   = busy;
      end
      `CCR_OFS_MODE: begin
        rd_mux[`CCR_MODE_RSZ_FEED] = rsz_feed;
        rd_mux[`CCR_MODE_VP2MEM]   = vp2mem;
        rd_mux[`CCR_MODE_WEN]      = wen;
        rd_mux[`CCR_MODE_SYNC_EN]  = sync_en;
        rd_mux[`CCR_MODE_FIELD]    = field_status;
        rd_mux[`CCR_MODE_LPF]      = antialias_filter_on;
        rd_mux[`CCR_MODE_FMT_HI:`CCR_MODE_FMT_LO] = fmt;
      end
      `CCR_OFS_IRQ_STAT: rd_mux[1:0] = irq_stat;
      `CCR_OFS_IRQ_EN:   rd_mux[1:0] = irq_en;
      `CCR_OFS_MEM_START: rd_mux = {4'h0, start_line, 4'h0, start_pixel};
      `CCR_OFS_FRAME: rd_mux = {sync_out, 3'h0, frame_last, 4'h0, line_last};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= 1'b1;
      if (setup) begin
        prdata  <= pwrite ? 32'h0000_0000 : rd_mux;
        pslverr <= ~map_hit;
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable      <= 1'b0;
      rsz_feed    <= 1'b0;
      vp2mem      <= 1'b0;
      wen         <= 1'b0;
      sync_en     <= 1'b0;
      antialias_filter_on         <= 1'b0;
      fmt         <= `CCR_FMT_RAW;
      irq_en      <= 2'b00;
      start_line  <= `CCR_RST_MEM_START;
      start_pixel <= 12'h000;
      line_last   <= `CCR_RST_LINE_LAST;
      frame_last  <= `CCR_RST_FRAME_LAST;
      sync_out    <= 1'b0;
    end else if (wr_acc) begin
      case (paddr)
        `CCR_OFS_CTRL: enable <= pwdata[`CCR_CTRL_ENABLE];
        `CCR_OFS_MODE: begin
          // Field status is read-only; reserved bits are dropped
          rsz_feed <= pwdata[`CCR_MODE_RSZ_FEED];
          vp2mem   <= pwdata[`CCR_MODE_VP2MEM];
          wen      <= pwdata[`CCR_MODE_WEN];
          sync_en  <= pwdata[`CCR_MODE_SYNC_EN];
          antialias_filter_on      <= pwdata[`CCR_MODE_LPF];
          fmt      <= pwdata[`CCR_MODE_FMT_HI:`CCR_MODE_FMT_LO];
        end
        `CCR_OFS_IRQ_EN: irq_en <= pwdata[1:0];
        `CCR_OFS_MEM_START: begin
          start_pixel <= pwdata[11:0];
          start_line  <= pwdata[27:16];
        end
        `CCR_OFS_FRAME: begin
          line_last  <= pwdata[11:0];
          frame_last <= pwdata[27:16];
          sync_out   <= pwdata[`CCR_FRAME_OUT];
        end
        default: begin
          sync_out <= sync_out;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupts: events set sticky bits whatever the enable bit says;
  // an event in the clearing cycle survives the clear.
  always @* begin
    next_irq = |(next_stat & irq_en);
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat <= 2'b00;
      irq      <= 1'b0;
    end else begin
      irq_stat <= next_stat;
      irq      <= next_irq;
    end
  end
endmodule // ccr_capture_ctrl
`default_nettype wire

// ==== verification/ccr_sensor_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module ccr_sensor_model (
  output logic        pix_clk,  // Pixel clock, still between frames
  output logic        vsync_in, // Vertical sync, active high
  output logic        hsync_in, // Horizontal sync, active high
  output logic        field_in, // Field id
  output logic [15:0] pix_data  // Pixel data
);
  initial begin
    pix_clk = 1'b0;
    vsync_in = 1'b0;
    hsync_in = 1'b0;
    field_in = 1'b0;
    pix_data = 16'h1234;
  end
  ////////////////////////////////////////////////////////////
  // Data moves 160 ns after each rise, so it holds past the 150 ns window
  // Data toggles every pixel so the low-pass result stands apart from bypass
  task automatic frame(input int lines, input int px, input logic fld);
    field_in = fld;
    vsync_in = 1'b1;
    #1000 vsync_in = 1'b0;
    #1000;
    repeat (lines) begin
      hsync_in = 1'b1;
      #400 hsync_in = 1'b0;
      #400;
      repeat (px) begin
        pix_clk = 1'b1;
        #100 pix_clk = 1'b0;
        #60 pix_data = ~pix_data;
        #40;
      end
    end
    #1000;
  endtask
endmodule // ccr_sensor_model
`default_nettype wire

// ==== verification/ccr_capture_ctrl_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "ccr_defs.vh"
module ccr_capture_ctrl_asserts (
  input wire logic        pclk,         // Clock
  input wire logic        presetn,      // Reset, active low
  input wire logic        psel,         // APB select
  input wire logic        penable,      // APB access phase
  input wire logic        pwrite,       // APB write
  input wire logic [11:0] paddr,        // APB address
  input wire logic [31:0] pwdata,       // APB write data
  input wire logic [31:0] prdata,       // APB read data
  input wire logic        pready,       // APB ready
  input wire logic        pslverr,      // APB error
  input wire logic        vsync_oe_n,   // Vertical sync enable
  input wire logic        hsync_oe_n,   // Horizontal sync enable
  input wire logic        mem_wr_valid, // Formatter write
  input wire logic        mem_rd_valid, // Readback valid
  input wire logic [15:0] mem_rd_data,  // Readback data
  input wire logic        rsz_valid,    // Resizer valid
  input wire logic [15:0] rsz_data,     // Resizer data
  input wire logic        irq           // Interrupt
);
  logic        ctrl_en;
  logic [31:0] mode_q;
  logic [1:0]  ien_q;
  logic        out_q;
  wire acc = psel && penable;
  wire rd = acc && !pwrite;
  wire mapped = paddr inside {`CCR_OFS_CTRL, `CCR_OFS_MODE, `CCR_OFS_IRQ_STAT,
    `CCR_OFS_IRQ_CLR, `CCR_OFS_IRQ_EN, `CCR_OFS_MEM_START, `CCR_OFS_FRAME};
  // Shadow of what software wrote, so read-back can be judged
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_en <= 1'b0;
      mode_q  <= 32'h0;
      ien_q   <= 2'h0;
      out_q   <= 1'b0;
    end else if (acc && pwrite && pready) begin
      if (paddr == `CCR_OFS_CTRL) ctrl_en <= pwdata[0];
      if (paddr == `CCR_OFS_MODE) mode_q <= pwdata;
      if (paddr == `CCR_OFS_IRQ_EN) ien_q <= pwdata[1:0];
      if (paddr == `CCR_OFS_FRAME) out_q <= pwdata[31];
    end
  end
  ////////////////////////////////////////////////////////////
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ctrl_read_a: assert property (rd && paddr == `CCR_OFS_CTRL |->
    prdata[31:2] == 30'h0 && prdata[0] == ctrl_en) else $error("control read wrong");
  mode_read_a: assert property (rd && paddr == `CCR_OFS_MODE |->
    prdata[31:20] == 12'h0 && prdata[11:0] == 12'h0 && prdata[19:16] == mode_q[19:16]
    && prdata[14:12] == mode_q[14:12]) else $error("mode read wrong");
  unmapped_err_a: assert property (acc |-> pslverr == !mapped
    && (mapped || pwrite || prdata == 32'h0)) else $error("unmapped access wrong");
  feed_on_a: assert property (mem_rd_valid && mode_q[19] |=>
    rsz_valid && rsz_data == $past(mem_rd_data)) else $error("feed missing");
  feed_off_a: assert property (!(mem_rd_valid && mode_q[19]) |=> !rsz_valid)
    else $error("feed unexpected");
  fmt_gate_a: assert property (mem_wr_valid |-> $past(mode_q[13:12]) != 2'h3)
    else $error("write in reserved format");
  write_enable_a: assert property (mem_wr_valid |-> $past(ctrl_en))
    else $error("write while disabled");
  irq_mask_a: assert property ((ien_q == 2'h0) [*2] |-> !irq)
    else $error("irq while masked");
  sync_drive_a: assert property (vsync_oe_n == !$past(mode_q[16] && out_q)
    && hsync_oe_n == vsync_oe_n) else $error("sync drive wrong");
  cover property (rsz_valid);
  cover property (mem_wr_valid);
  cover property (irq);
  cover property (acc && pslverr);
endmodule // ccr_capture_ctrl_asserts
bind ccr_capture_ctrl ccr_capture_ctrl_asserts u_chk (.*);
`default_nettype wire

// ==== verification/ccr_capture_ctrl_test.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "ccr_defs.vh"
module ccr_capture_ctrl_test;
  typedef struct {logic w; logic [11:0] a; logic [31:0] d; logic [31:0] q; logic e;} ccr_row_t;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic        pready, pslverr, er, pix_clk, vsync_in, hsync_in, field_in;
  logic        vsync_out, vsync_oe_n, hsync_out, hsync_oe_n, mem_wr_valid, rsz_valid, irq;
  logic        vp_valid = 0, vp_sol = 0, vp_sof = 0, mem_rd_valid = 0;
  logic [15:0] pix_data, vp_data = 0, mem_wr_data, mem_rd_data = 0, rsz_data;
  int          fail_count = 0, tests_run = 0, wr_n = 0, base;
  ccr_row_t    rows[9] = '{'{0, `CCR_OFS_CTRL, 0, 0, 0}, '{0, `CCR_OFS_MODE, 0, 0, 0},
    '{0, `CCR_OFS_IRQ_EN, 0, 0, 0}, '{1, `CCR_OFS_MODE, 32'hffff_ffff, 0, 0},
    '{0, `CCR_OFS_MODE, 0, 32'h000f_7000, 0}, '{1, `CCR_OFS_CTRL, 32'hffff_ffff, 0, 0},
    '{0, `CCR_OFS_CTRL, 0, 32'h1, 0}, '{0, 12'h40c, 0, 0, 1}, '{1, 12'h40c, 1, 0, 1}};
  ccr_capture_ctrl uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pix_clk(pix_clk), .vsync_in(vsync_in), .hsync_in(hsync_in),
    .field_in(field_in), .pix_data(pix_data), .vsync_out(vsync_out),
    .vsync_oe_n(vsync_oe_n), .hsync_out(hsync_out), .hsync_oe_n(hsync_oe_n),
    .vp_valid(vp_valid), .vp_sol(vp_sol), .vp_sof(vp_sof), .vp_data(vp_data),
    .mem_wr_valid(mem_wr_valid), .mem_wr_data(mem_wr_data), .mem_rd_valid(mem_rd_valid),
    .mem_rd_data(mem_rd_data), .rsz_valid(rsz_valid), .rsz_data(rsz_data), .irq(irq));
  ccr_sensor_model sensor (.pix_clk(pix_clk), .vsync_in(vsync_in), .hsync_in(hsync_in),
    .field_in(field_in), .pix_data(pix_data));
  always #12.5 pclk = ~pclk;
  // Counted on the falling edge, where the strobe has settled
  always @(negedge pclk) if (mem_wr_valid === 1'b1) wr_n++;
  ////////////////////////////////////////////////////////////
  task automatic close_out;
    if (fail_count == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    for (n = 0; n < 16; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
    if (n == 16) begin
      fail_count++;
      $display("[ERR] %0t bus timeout", $time);
      close_out();
    end
  endtask
  // Video port strobes last one cycle, then data is scrambled
  task automatic vpx(input logic [2:0] v, input logic [15:0] d);
    @(posedge pclk);
    {vp_sof, vp_sol, vp_valid} <= v;
    vp_data <= d;
    @(posedge pclk);
    {vp_sof, vp_sol, vp_valid} <= 3'b000;
    vp_data <= ~d;
  endtask
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1;
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w) chk(rd, rows[i].q);
      chk({31'h0, er}, {31'h0, rows[i].e});
    end
    for (int f = 0; f < 4; f++) begin
      apb(1, `CCR_OFS_MODE, 32'h0003_0000 | (f << 12));
      base = wr_n;
      sensor.frame(2, 4, f[0]);
      chk(wr_n - base, f == 3 ? 0 : f == 2 ? 4 : 8);
      if (f == 0) chk({31'h0, mem_wr_data == 16'h1234 || mem_wr_data == 16'hedcb}, 1);
      apb(0, `CCR_OFS_MODE, 0);
      chk({31'h0, rd[15]}, {31'h0, f[0]});
    end
    apb(1, `CCR_OFS_MODE, 32'h0003_4000);
    sensor.frame(2, 4, 0);
    chk({16'h0, mem_wr_data}, 32'h7fff);
    apb(0, `CCR_OFS_CTRL, 0);
    chk(rd, 32'h3);
    base = wr_n;
    fork
      sensor.frame(2, 4, 0);
      begin
        #2500 apb(1, `CCR_OFS_MODE, 32'h0001_0000);
      end
    join
    chk(wr_n - base, 8);
    apb(1, `CCR_OFS_CTRL, 0);
    apb(1, `CCR_OFS_IRQ_CLR, 3);
    base = wr_n;
    sensor.frame(2, 4, 0);
    chk(wr_n - base, 0);
    apb(0, `CCR_OFS_CTRL, 0);
    chk(rd, 0);
    apb(0, `CCR_OFS_IRQ_STAT, 0);
    chk({31'h0, rd[0]}, 1);
    chk({31'h0, irq}, 0);
    apb(1, `CCR_OFS_IRQ_EN, 1);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 1);
    apb(1, `CCR_OFS_IRQ_CLR, 1);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 0);
    apb(1, `CCR_OFS_CTRL, 1);
    apb(1, `CCR_OFS_MODE, 32'h0005_0000);
    apb(1, `CCR_OFS_MEM_START, 1);
    base = wr_n;
    vpx(3'b001, 16'h1111);
    chk(wr_n - base, 0);
    sensor.frame(1, 0, 0);
    base = wr_n;
    vpx(3'b100, 0);
    vpx(3'b010, 0);
    vpx(3'b001, 16'h2222);
    vpx(3'b001, 16'hbeef);
    @(posedge pclk);
    chk(wr_n - base, 1);
    chk({16'h0, mem_wr_data}, 32'hbeef);
    for (int f = 0; f < 2; f++) begin
      apb(1, `CCR_OFS_MODE, f << 19);
      @(posedge pclk);
      mem_rd_valid <= 1;
      mem_rd_data <= 16'ha5c3;
      @(posedge pclk);
      mem_rd_valid <= 0;
      @(posedge pclk);
      chk({31'h0, rsz_valid}, f);
      chk({16'h0, rsz_data}, f ? 32'ha5c3 : 32'h0);
    end
    apb(1, `CCR_OFS_FRAME, 32'h8000_0000);
    apb(1, `CCR_OFS_MODE, 32'h0001_0000);
    repeat (3) @(posedge pclk);
    chk({31'h0, vsync_oe_n}, 0);
    chk({31'h0, hsync_oe_n}, 0);
    chk({31'h0, hsync_out}, 1);
    chk({31'h0, vsync_out}, 0);
    // Reset in mid-run: pins released and settings back to defaults
    presetn <= 0;
    repeat (2) @(posedge pclk);
    chk({31'h0, vsync_oe_n}, 1);
    chk({31'h0, irq}, 0);
    presetn <= 1;
    apb(0, `CCR_OFS_CTRL, 0);
    chk(rd, 0);
    apb(0, `CCR_OFS_MODE, 0);
    chk(rd, 0);
    apb(0, `CCR_OFS_FRAME, 0);
    chk(rd, {4'h0, `CCR_RST_FRAME_LAST, 4'h0, `CCR_RST_LINE_LAST});
    close_out();
  end
endmodule // ccr_capture_ctrl_test
`default_nettype wire
